// ==== flash_prot_consts.vh ====
/*
 * Shared constants of the sector protection lock block: command
 * opcodes, status data bit positions, register map of the control
 * port and reset values.
 * Assumes it is included by its bare name before any module that
 * uses it.
 */
`ifndef FLASH_PROT_CONSTS_VH
`define FLASH_PROT_CONSTS_VH

// Command opcodes seen on the serial link
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_STATUS 8'h01
`define OP_PROTECT 8'h36
`define OP_UNPROTECT 8'h39

// Status write data fields
`define LOCK_POS 7
`define GLOB_HI 5
`define GLOB_LO 2

// Address bytes after a sector command and sector field in the address
`define ADDR_BYTES 2'h3
`define SECT_LSB 16

// Control port register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SECT_LO 8'h08
`define REG_SECT_HI 8'h0c
`define REG_RESET 8'h10
`define REG_DISCARD 8'h14

// Field positions and reset values
`define CTRL_EN_POS 0
`define CTRL_RESET 1'b1
`define SECTOR_RESET 1'b1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== sync_2ff.v ====
/*
 * Two flip-flop synchroniser for a group of independent levels.
 * Assumes each bit is a slow level or a clock far slower than clk;
 * bits are not kept coherent with each other.
 */
`timescale 1ns/1ps
module sync_2ff
#(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
)
(
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);

reg [WIDTH-1:0] meta;

// First stage feeds only the second stage
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        meta <= INIT;
        q <= INIT;
    end
    else
    begin
        meta <= d;
        q <= meta;
    end
end

endmodule

// ==== spi_frame_rx.v ====
/*
 * Serial frame receiver: finds link clock rising edges and frame
 * boundaries on already synchronised pins and assembles bytes, MSB
 * first (modes 0 and 3 both sample on the rising edge).
 * Assumes inputs come from sync_2ff on the same clk.
 */
`timescale 1ns/1ps
module spi_frame_rx
(
    input wire clk,
    input wire rst,
    input wire sclk_s,
    input wire cs_n_s,
    input wire mosi_s,
    output reg byte_valid,
    output reg [7:0] byte_data,
    output reg frame_start,
    output reg frame_end,
    output wire aligned,
    output wire active
);

reg sclk_d;
reg cs_n_d;
reg [2:0] bit_cnt;
reg [6:0] shift;

assign aligned = (bit_cnt == 3'h0);
assign active = ~cs_n_s;

// Edge finding and byte assembly; edges outside a frame are ignored
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        sclk_d <= 1'b0;
        cs_n_d <= 1'b1;
        bit_cnt <= 3'h0;
        shift <= 7'h00;
        byte_valid <= 1'b0;
        byte_data <= 8'h00;
        frame_start <= 1'b0;
        frame_end <= 1'b0;
    end
    else
    begin
        sclk_d <= sclk_s;
        cs_n_d <= cs_n_s;
        frame_start <= cs_n_d & ~cs_n_s;
        frame_end <= ~cs_n_d & cs_n_s;
        byte_valid <= 1'b0;
        if (cs_n_d & ~cs_n_s)
        begin
            bit_cnt <= 3'h0;
        end
        else if (~cs_n_s && sclk_s && !sclk_d)
        begin
            shift <= {shift[5:0], mosi_s};
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
                byte_valid <= 1'b1;
                byte_data <= {shift, mosi_s};
            end
        end
    end
end

endmodule

// ==== flash_protect_lock.v ====
/*
 * Sector protection and lock logic of a serial flash, with an
 * AXI4-Lite slave for supervision. Decodes write enable, write
 * disable, status write, sector protect and sector unprotect frames
 * and keeps the per-sector protection bits, the protection lock bit
 * and the write enable latch.
 * Assumes sclk, cs_n, mosi and wp_n are asynchronous pins, the link
 * clock is well below a quarter of clk, and an AXI master on clk.
 */
`timescale 1ns/1ps
`include "flash_prot_consts.vh"
module flash_protect_lock
#(
    parameter SECTORS = 64,
    parameter SECT_W = 6
)
(
    input wire clk,
    input wire rst,
    input wire sclk,
    input wire cs_n,
    input wire mosi,
    input wire wp_n,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [SECTORS-1:0] sector_protect,
    output reg protection_lock_bit,
    output reg write_enable_latch
);

// Frame decoder states, one-hot
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_OPCODE = 3'b010;
localparam [2:0] ST_ARGS = 3'b100;

wire sclk_s;
wire cs_n_s;
wire mosi_s;
wire wp_n_s;
wire rx_valid;
wire [7:0] rx_data;
wire rx_start;
wire rx_end;
wire rx_aligned;
wire rx_active;

reg [2:0] state;
reg [7:0] opcode;
reg [1:0] nbytes;
reg [23:0] addr;
reg [7:0] status_data;
reg link_enable;
reg soft_reset;
reg [7:0] discard_count;

reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
reg aw_held;
reg w_held;

// Sector index from a byte address inside the array
function [SECT_W-1:0] sector_of;
    input [23:0] a;
    begin
        sector_of = a[`SECT_LSB +: SECT_W];
    end
endfunction

// Saturating event counter step; wrapping would hide a flood
function [7:0] sat_inc;
    input [7:0] v;
    begin
        sat_inc = (v == 8'hff) ? v : v + 8'h01;
    end
endfunction

// Register read decode; unmapped offsets are flagged by the caller
function [31:0] reg_read;
    input [7:0] a;
    begin
        case (a)
            `REG_CTRL: reg_read = {31'h0, link_enable};
            `REG_STATUS: reg_read = {28'h0, rx_active, wp_n_s,
                protection_lock_bit, write_enable_latch};
            `REG_SECT_LO: reg_read = sector_protect[31:0];
            `REG_SECT_HI: reg_read = sector_protect[63:32];
            `REG_DISCARD: reg_read = {24'h0, discard_count};
            default: reg_read = 32'h0;
        endcase
    end
endfunction

function mapped;
    input [7:0] a;
    begin
        mapped = (a == `REG_CTRL) || (a == `REG_STATUS) ||
            (a == `REG_SECT_LO) || (a == `REG_SECT_HI) ||
            (a == `REG_RESET) || (a == `REG_DISCARD);
    end
endfunction

// All pins cross into clk here; the lock pin idles high (unlocked)
sync_2ff #(.WIDTH(4), .INIT(4'b1010)) pin_sync
(
    .clk(clk),
    .rst(rst),
    .d({cs_n, sclk, wp_n, mosi}),
    .q({cs_n_s, sclk_s, wp_n_s, mosi_s})
);

spi_frame_rx rx
(
    .clk(clk),
    .rst(rst),
    .sclk_s(sclk_s),
    .cs_n_s(cs_n_s),
    .mosi_s(mosi_s),
    .byte_valid(rx_valid),
    .byte_data(rx_data),
    .frame_start(rx_start),
    .frame_end(rx_end),
    .aligned(rx_aligned),
    .active(rx_active)
);

// Frame decoder: opcode byte, then up to three argument bytes
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        state <= ST_IDLE;
        opcode <= 8'h00;
        nbytes <= 2'h0;
        addr <= 24'h0;
        status_data <= 8'h00;
    end
    else
    begin
        case (state)
            ST_IDLE:
            begin
                if (rx_start)
                begin
                    state <= ST_OPCODE;
                    nbytes <= 2'h0;
                end
            end
            ST_OPCODE:
            begin
                if (rx_end)
                begin
                    state <= ST_IDLE;
                end
                else if (rx_valid)
                begin
                    opcode <= rx_data;
                    state <= ST_ARGS;
                end
            end
            ST_ARGS:
            begin
                if (rx_end)
                begin
                    state <= ST_IDLE;
                end
                else if (rx_valid && nbytes != `ADDR_BYTES)
                begin
                    // Extra bytes past the address are ignored
                    addr <= {addr[15:0], rx_data};
                    nbytes <= nbytes + 2'h1;
                    if (nbytes == 2'h0)
                    begin
                        status_data <= rx_data;
                    end
                end
            end
            default:
            begin
                state <= ST_IDLE;
            end
        endcase
    end
end

// Command execution at frame end, so every bit changes in one cycle
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        sector_protect <= {SECTORS{`SECTOR_RESET}};
        protection_lock_bit <= 1'b0;
        write_enable_latch <= 1'b0;
        discard_count <= 8'h00;
    end
    else if (soft_reset)
    begin
        sector_protect <= {SECTORS{`SECTOR_RESET}};
        protection_lock_bit <= 1'b0;
        write_enable_latch <= 1'b0;
    end
    else if (link_enable && rx_end && state == ST_ARGS)
    begin
        if (!rx_aligned)
        begin
            // Torn frame: sector commands still drop the latch
            if (opcode == `OP_PROTECT || opcode == `OP_UNPROTECT)
            begin
                write_enable_latch <= 1'b0;
            end
        end
        else
        begin
            case (opcode)
                `OP_WRITE_ENABLE:
                begin
                    write_enable_latch <= 1'b1;
                end
                `OP_WRITE_DISABLE:
                begin
                    write_enable_latch <= 1'b0;
                end
                `OP_WRITE_STATUS:
                begin
                    // Global patterns ride on this command alone
                    if (write_enable_latch && nbytes != 2'h0)
                    begin
                        write_enable_latch <= 1'b0;
                        if (protection_lock_bit && !wp_n_s)
                        begin
                            // Hardware locked: lock and sectors hold
                            discard_count <=
                                sat_inc(discard_count);
                        end
                        else
                        begin
                            // Only bit seven is kept from the data
                            protection_lock_bit <=
                                status_data[`LOCK_POS];
                            // Soft lock blocks the pattern this time
                            if (!protection_lock_bit)
                            begin
                                if (&status_data[`GLOB_HI:`GLOB_LO])
                                begin
                                    sector_protect <=
                                        {SECTORS{1'b1}};
                                end
                                else if (~|status_data[`GLOB_HI:`GLOB_LO])
                                begin
                                    sector_protect <=
                                        {SECTORS{1'b0}};
                                end
                                // Mixed patterns fall through untouched
                            end
                        end
                    end
                end
                `OP_PROTECT:
                begin
                    if (write_enable_latch && nbytes == `ADDR_BYTES)
                    begin
                        write_enable_latch <= 1'b0;
                        if (protection_lock_bit)
                        begin
                            discard_count <= sat_inc(discard_count);
                        end
                        else
                        begin
                            sector_protect[sector_of(addr)] <= 1'b1;
                        end
                    end
                end
                `OP_UNPROTECT:
                begin
                    if (write_enable_latch && nbytes == `ADDR_BYTES)
                    begin
                        write_enable_latch <= 1'b0;
                        if (protection_lock_bit)
                        begin
                            discard_count <= sat_inc(discard_count);
                        end
                        else
                        begin
                            sector_protect[sector_of(addr)] <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    discard_count <= discard_count;
                end
            endcase
        end
    end
end

// Write channel: address and data taken in either order
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `RESP_OKAY;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h0;
        w_strb <= 4'h0;
        link_enable <= `CTRL_RESET;
        soft_reset <= 1'b0;
    end
    else
    begin
        soft_reset <= 1'b0;
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_addr <= s_axi_awaddr;
            aw_held <= 1'b1;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_held <= 1'b1;
            s_axi_wready <= 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? `RESP_OKAY : `RESP_SLVERR;
            if (aw_addr == `REG_CTRL && w_strb[0])
            begin
                link_enable <= w_data[`CTRL_EN_POS];
            end
            // Writing one here restores the power-up protection state
            if (aw_addr == `REG_RESET && w_strb[0] && w_data[0])
            begin
                soft_reset <= 1'b1;
            end
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
        end
    end
end

// Read channel: one outstanding read, data one cycle after address
always @(posedge clk or posedge rst)
begin
    if (rst)
    begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
        if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= reg_read(s_axi_araddr);
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY :
                `RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
end

endmodule

// ==== flash_protect_lock_props.sv ====
/* Checker for the sector protection lock block: lock, sector and
   register port relations seen on the top ports.
   Assumes it is bound to flash_protect_lock, one clock, reset high. */
`timescale 1ns/1ps
module flash_protect_lock_props
#(
    parameter SECTORS = 64
)
(
    input wire clk,
    input wire rst,
    input wire wp_n,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire [SECTORS-1:0] sector_protect,
    input wire protection_lock_bit,
    input wire write_enable_latch
);
    localparam [SECTORS-1:0] ALL1 = {SECTORS{1'b1}};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // Both write channels taken at one edge
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // No bus answer nearby, since a soft reset could clear the lock
    sequence s_hw_locked;
        (protection_lock_bit && !wp_n && !s_axi_bvalid) [*4];
    endsequence
    a_reset_state: assert property ($fell(rst) |->
        sector_protect == ALL1 && !protection_lock_bit && !write_enable_latch)
        else $error("reset state wrong");
    a_locked_frozen: assert property (
        $past(protection_lock_bit) && protection_lock_bit
        |-> $stable(sector_protect)) else $error("locked sectors changed");
    a_hw_lock_held: assert property (s_hw_locked |=>
        protection_lock_bit) else $error("hardware lock released");
    a_sect_needs_latch: assert property (
        $changed(sector_protect) && sector_protect != ALL1
        |-> $past(write_enable_latch) || $past(write_enable_latch, 2))
        else $error("sectors cleared without latch");
    a_uniform_update: assert property ($changed(sector_protect) |->
        sector_protect == ALL1 || sector_protect == '0
        || $onehot(sector_protect ^ $past(sector_protect)))
        else $error("sectors updated piecemeal");
    a_lock_needs_latch: assert property (
        $rose(protection_lock_bit)
        |-> $past(write_enable_latch) || $past(write_enable_latch, 2))
        else $error("lock set without latch");
    a_write_answer: assert property (s_write_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read not answered");
endmodule

bind flash_protect_lock flash_protect_lock_props #(.SECTORS(SECTORS))
    i_flash_protect_lock_props (.clk(clk), .rst(rst), .wp_n(wp_n),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .sector_protect(sector_protect),
    .protection_lock_bit(protection_lock_bit),
    .write_enable_latch(write_enable_latch));

// ==== spi_host_model.sv ====
/* Serial host model: sends whole command frames in mode 0.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
`include "flash_prot_consts.vh"
module spi_host_model
(
    output reg sclk,
    output reg cs_n,
    output reg mosi
);
    integer i;
    // Idle: link clock stands low, device deselected
    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Four bytes, MSB first; trailing bytes are ignored by the device,
    // so one frame length serves every command
    task send_frame(input [31:0] f);
        begin
            #3;
            cs_n = 1'b0;
            for (i = 31; i >= 0; i = i - 1)
            begin
                mosi = f[i];
                #40 sclk = 1'b1;
                #40 sclk = 1'b0;
            end
            #40 cs_n = 1'b1;
            // Released line must not keep showing the last bit
            mosi = ~mosi;
            #80;
        end
    endtask
    // Latch set first, then the status write carrying the pattern
    task status_write(input [7:0] d);
        begin
            send_frame({`OP_WRITE_ENABLE, 24'h000000});
            send_frame({`OP_WRITE_STATUS, d, 16'h0000});
        end
    endtask
    // Sector command with its three address bytes
    task sector_cmd(input [7:0] op, input [7:0] s);
        begin
            send_frame({`OP_WRITE_ENABLE, 24'h000000});
            send_frame({op, s, 16'h0000});
        end
    endtask
endmodule

// ==== flash_protect_lock_bench.sv ====
/* Self-checking bench of the sector protection lock block.
   Assumes the serial host model and the bound checker. */
`timescale 1ns/1ps
`include "flash_prot_consts.vh"
module flash_protect_lock_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg wp_n = 1'b1;
    reg [7:0] s_axi_awaddr = 8'h00;
    reg s_axi_awvalid = 1'b0;
    reg [31:0] s_axi_wdata = 32'h0;
    reg s_axi_wvalid = 1'b0;
    reg s_axi_bready = 1'b0;
    reg [7:0] s_axi_araddr = 8'h00;
    reg s_axi_arvalid = 1'b0;
    reg s_axi_rready = 1'b0;
    wire sclk, cs_n, mosi, s_axi_awready, s_axi_wready, s_axi_bvalid;
    wire s_axi_arready, s_axi_rvalid, protection_lock_bit;
    wire write_enable_latch;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [63:0] sector_protect;
    integer num_errors = 0;
    integer samples_checked = 0;
    integer r;
    // Row: wp_n, status data, expected sectors (all), expected lock
    reg [10:0] rows [0:10];
    always #4 clk = ~clk;
    flash_protect_lock i_flash_protect_lock (.clk(clk), .rst(rst),
        .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sector_protect(sector_protect),
        .protection_lock_bit(protection_lock_bit),
        .write_enable_latch(write_enable_latch));
    spi_host_model i_spi_host_model (.sclk(sclk), .cs_n(cs_n),
        .mosi(mosi));
    task tally_and_finish;
        begin
            $display("checked %0d errors %0d", samples_checked, num_errors);
            if (num_errors == 0 && samples_checked > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    task check(input [63:0] exp, input [63:0] got, input [63:0] what);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                num_errors = num_errors + 1;
                $display("unexpected %0s: expected %h seen %h",
                    what, exp, got);
            end
        end
    endtask
    // One bus cycle; each channel dropped once taken, bounded wait
    task axi(input wr, input [7:0] a, input [31:0] d, input [1:0] er);
        integer n;
        begin
            @(posedge clk);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= wr;
            s_axi_wvalid <= wr;
            s_axi_bready <= wr;
            s_axi_arvalid <= !wr;
            s_axi_rready <= !wr;
            for (n = 0; n < 100; n = n + 1)
            begin
                @(posedge clk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
                if (s_axi_bvalid || s_axi_rvalid)
                    break;
            end
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
            if (n == 100)
            begin
                num_errors = num_errors + 1;
                tally_and_finish;
            end
            if (wr)
                check(er, s_axi_bresp, "bresp");
            else
                check({er, d}, {s_axi_rresp, s_axi_rdata}, "read");
        end
    endtask
    initial
    begin
        rows[0] = {1'b1, 8'h43, 1'b0, 1'b0};
        rows[1] = {1'b1, 8'h3c, 1'b1, 1'b0};
        rows[2] = {1'b1, 8'h04, 1'b1, 1'b0};
        rows[3] = {1'b0, 8'h80, 1'b0, 1'b1};
        rows[4] = {1'b0, 8'h3c, 1'b0, 1'b1};
        rows[5] = {1'b0, 8'h00, 1'b0, 1'b1};
        rows[6] = {1'b1, 8'h3c, 1'b0, 1'b0};
        rows[7] = {1'b1, 8'hbc, 1'b1, 1'b1};
        rows[8] = {1'b1, 8'h40, 1'b1, 1'b0};
        rows[9] = {1'b1, 8'h20, 1'b1, 1'b0};
        rows[10] = {1'b1, 8'h00, 1'b0, 1'b0};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({64{1'b1}}, sector_protect, "sectors");
        check(2'b00, {protection_lock_bit, write_enable_latch},
            "lock");
        // Table of status writes; state carries from row to row
        for (r = 0; r < 11; r = r + 1)
        begin
            @(posedge clk);
            wp_n <= rows[r][10];
            repeat (4) @(posedge clk);
            i_spi_host_model.status_write(rows[r][9:2]);
            check({64{rows[r][1]}}, sector_protect, "sectors");
            check(rows[r][0], protection_lock_bit, "lock");
            check(1'b0, write_enable_latch, "latch");
        end
        // Write disable drops the latch, so the status write is refused
        i_spi_host_model.send_frame({`OP_WRITE_ENABLE, 24'h000000});
        i_spi_host_model.send_frame({`OP_WRITE_DISABLE, 24'h000000});
        check(1'b0, write_enable_latch, "latch");
        i_spi_host_model.send_frame({`OP_WRITE_STATUS, 8'h3c, 16'h0000});
        check(64'h0, sector_protect, "sectors");
        // Locked: unprotect is discarded and the latch is cleared
        i_spi_host_model.status_write(8'hbc);
        i_spi_host_model.send_frame({`OP_WRITE_ENABLE, 24'h000000});
        check(1'b1, write_enable_latch, "latch");
        i_spi_host_model.send_frame({`OP_UNPROTECT, 24'h050000});
        check({64{1'b1}}, sector_protect, "sectors");
        check(1'b0, write_enable_latch, "latch");
        // Single sector commands after a global protect
        i_spi_host_model.status_write(8'h00);
        check(1'b0, protection_lock_bit, "lock");
        i_spi_host_model.sector_cmd(`OP_UNPROTECT, 8'h05);
        check(~(64'h1 << 5), sector_protect, "sectors");
        axi(1'b0, `REG_SECT_LO, 32'hffffffdf, `RESP_OKAY);
        axi(1'b0, `REG_SECT_HI, 32'hffffffff, `RESP_OKAY);
        i_spi_host_model.sector_cmd(`OP_PROTECT, 8'h05);
        check({64{1'b1}}, sector_protect, "sectors");
        // Register port: map, refusals, discard count
        axi(1'b1, `REG_CTRL, 32'h1, `RESP_OKAY);
        axi(1'b0, `REG_CTRL, 32'h1, `RESP_OKAY);
        axi(1'b0, `REG_STATUS, 32'h4, `RESP_OKAY);
        axi(1'b0, `REG_DISCARD, 32'h3, `RESP_OKAY);
        axi(1'b0, 8'h20, 32'h0, `RESP_SLVERR);
        axi(1'b1, 8'h20, 32'h1, `RESP_SLVERR);
        // Link disabled: frames are ignored until enabled again
        axi(1'b1, `REG_CTRL, 32'h0, `RESP_OKAY);
        i_spi_host_model.send_frame({`OP_WRITE_ENABLE, 24'h000000});
        check(1'b0, write_enable_latch, "latch");
        axi(1'b1, `REG_CTRL, 32'h1, `RESP_OKAY);
        // Soft reset over the bus restores protection and unlocks
        i_spi_host_model.status_write(8'h80);
        check(64'h0, sector_protect, "sectors");
        axi(1'b1, `REG_RESET, 32'h1, `RESP_OKAY);
        repeat (2) @(posedge clk);
        check({64{1'b1}}, sector_protect, "sectors");
        check(1'b0, protection_lock_bit, "lock");
        // Reset in mid-run restores full protection
        i_spi_host_model.status_write(8'h00);
        check(64'h0, sector_protect, "sectors");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        check({64{1'b1}}, sector_protect, "sectors");
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        tally_and_finish;
    end
endmodule
